/* tsc_pkg.sv */
// trigger sequencer control package: register layout, reset values, states
// assumes a 16-bit control/status word reached over a plain port
`default_nettype none
package tsc_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [3:0] tsc_addr_ctrl = 4'h0;
   localparam logic [3:0] tsc_addr_mask = 4'h1;
   localparam logic [3:0] tsc_addr_stat = 4'h2;
   localparam logic [3:0] tsc_addr_sdlim = 4'h3;
   localparam logic [3:0] tsc_addr_cnlim = 4'h4;
   localparam logic [3:0] tsc_addr_tmlim = 4'h5;
   localparam logic [3:0] tsc_addr_pwid = 4'h6;
   localparam logic [3:0] tsc_addr_cmd = 4'h7;
   // ----------------------------------------
   // control/status bit positions
   // ----------------------------------------
   localparam int tsc_b_enable = 15;
   localparam int tsc_b_sidl = 13;
   localparam int tsc_b_togl = 12;
   localparam int tsc_b_swt = 10;
   localparam int tsc_b_ssen = 9;
   localparam int tsc_b_ivis = 8;
   localparam int tsc_b_run = 7;
   localparam int tsc_b_wdto = 6;
   localparam int tsc_b_itm1 = 1;
   localparam int tsc_b_itm0 = 0;
   localparam logic [15:0] tsc_ctrl_impl = 16'hb7c3;
   localparam logic [15:0] tsc_ctrl_rst = 16'h0000;
   // ----------------------------------------
   // command word: op in [15:12], line in [3:0], option bit 0
   // ----------------------------------------
   localparam logic [3:0] tsc_op_trig = 4'h1;
   localparam logic [3:0] tsc_op_whi = 4'h2;
   localparam logic [3:0] tsc_op_wlo = 4'h3;
   localparam logic [3:0] tsc_op_ctrl = 4'h4;
   localparam logic [3:0] tsc_op_step = 4'h5;
   // status bits: 0 watchdog time-out, 1 trigger issued
   localparam int tsc_ev_w = 2;
   // ----------------------------------------
   // timing: watchdog time in ns, counts derived at 250 MHz
   // ----------------------------------------
   localparam int tsc_clk_mhz = 250;
   localparam int tsc_wdt_ns = 4000;
   localparam int tsc_wdt_cyc = (tsc_wdt_ns * tsc_clk_mhz) / 1000;
   typedef enum logic [1:0] {tsc_idle, tsc_fetch, tsc_wait, tsc_pulse} tsc_state_t;
endpackage
`default_nettype wire

/* tsc_trig_line.sv */
// one trigger output line: pulse or toggle
// assumes fire is a one-cycle strobe on mclk
`timescale 1ns/100ps
`default_nettype none
module tsc_trig_line #(
   parameter int pw_w = 8 // pulse width counter width
) (
   input wire logic mclk, // clock
   input wire logic rst, // async reset
   input wire logic fire, // execute trigger
   input wire logic toggle, // toggle mode
   input wire logic [pw_w-1:0] width, // pulse width in cycles
   output logic line // trigger output
);
   logic [pw_w-1:0] cnt;
   // ----------------------------------------
   // line drive
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         line <= 1'b0;
         cnt <= '0;
      end else if (fire && toggle) begin
         line <= ~line;
         cnt <= '0;
      end else if (fire) begin
         line <= 1'b1;
         cnt <= (width == '0) ? pw_w'(1) : width;
      end else if (cnt != '0) begin
         cnt <= cnt - pw_w'(1);
         if (cnt == pw_w'(1)) begin
            line <= 1'b0;
         end
      end
   end
endmodule // tsc_trig_line
`default_nettype wire

/* tsc_core.sv */
// trigger sequencer control and status with command interpreter
// assumes a one-cycle register port on mclk; idle and inputs from pins
//
// Operation
// - sequencer runs only while enable bit set
// - halt-in-idle stops sequencer during idle
// - toggle mode inverts addressed trigger line
// - pulse mode emits one width-long pulse
// - writing one triggers; zero does nothing
// - only control-command option reads software trigger
// - single-step bit selects single-step mode
// - visibility set: limit reads show live
// - visibility clear: limit reads show written
// - run bit starts; clearing stops execution
// - watchdog expiry sets time-out flag
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module tsc_core
   import tsc_pkg::*;
#(
   parameter int n_lines = 4, // trigger output lines
   parameter int n_in = 4, // trigger inputs
   parameter int wdt_cyc = tsc_wdt_cyc // watchdog count
) (
   input wire logic mclk, // clock
   input wire logic rst, // async reset
   input wire logic [3:0] addr, // register index
   input wire logic [15:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [15:0] rdata, // read data
   input wire logic idle_req, // device idle mode
   input wire logic [n_in-1:0] trig_in, // trigger inputs
   output logic [n_lines-1:0] trigger_output_line, // trigger outputs
   output logic irq // level interrupt
);
   import tsc_pkg::*;
   logic [15:0] ctrl;
   logic watchdog_timeout_flag;
   logic [15:0] step_delay_limit, loop_counter_limit, timer_limit;
   logic [15:0] step_delay_counter, loop_counter, sequence_timer;
   logic [7:0] pulse_width_setting;
   logic [15:0] cmd;
   logic cmd_pend;
   logic swt_pend;
   logic [tsc_ev_w-1:0] stat, mask;
   logic [1:0] idle_s;
   logic step_req;
   logic [n_in-1:0] in_m, in_q;
   logic idle_q;
   logic active;
   logic wd_exp;
   logic fire;
   logic step_ok;
   logic wait_done;
   tsc_state_t state;
   logic [15:0] ctrl_view;
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         idle_s <= 2'h0;
         in_m <= '0;
         in_q <= '0;
      end else begin
         idle_s <= {idle_s[0], idle_req};
         in_m <= trig_in;
         in_q <= in_m;
      end
   end
   assign idle_q = idle_s[1];
   // sequencer may act
   assign active = ctrl[tsc_b_enable] && !(ctrl[tsc_b_sidl] && idle_q);
   // ----------------------------------------
   // control register
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl <= tsc_ctrl_rst;
      end else if (wr && addr == tsc_addr_ctrl) begin
         ctrl <= wdata & tsc_ctrl_impl & ~(16'h0001 << tsc_b_wdto) & ~(16'h0001 << tsc_b_swt);
      end
   end
   // software trigger latch, writing zero is no action
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         swt_pend <= 1'b0;
      end else if (wr && addr == tsc_addr_ctrl && wdata[tsc_b_swt]) begin
         swt_pend <= 1'b1;
      end else if (state == tsc_wait && cmd[15:12] == tsc_op_ctrl && cmd[0] && swt_pend) begin
         swt_pend <= 1'b0;
      end
   end
   // ----------------------------------------
   // limit, pulse width and command registers
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         step_delay_limit <= 16'h0000;
         loop_counter_limit <= 16'h0000;
         timer_limit <= 16'h0000;
         pulse_width_setting <= 8'h00;
      end else if (wr) begin
         if (addr == tsc_addr_sdlim) step_delay_limit <= wdata;
         if (addr == tsc_addr_cnlim) loop_counter_limit <= wdata;
         if (addr == tsc_addr_tmlim) timer_limit <= wdata;
         if (addr == tsc_addr_pwid) pulse_width_setting <= wdata[7:0];
      end
   end
   // one command slot, loaded by software
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cmd <= 16'h0000;
         cmd_pend <= 1'b0;
      end else if (wr && addr == tsc_addr_cmd) begin
         cmd <= wdata;
         cmd_pend <= 1'b1;
      end else if (state == tsc_fetch) begin
         cmd_pend <= 1'b0;
      end
   end
   // single step: a control write with the step bit grants one command start
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         step_req <= 1'b0;
      end else if (wr && addr == tsc_addr_ctrl && wdata[tsc_b_ssen]) begin
         step_req <= 1'b1;
      end else if (state == tsc_fetch) begin
         step_req <= 1'b0;
      end
   end
   assign step_ok = !ctrl[tsc_b_ssen] || step_req;
   // ----------------------------------------
   // wait completion per command
   // ----------------------------------------
   always_comb begin
      wait_done = 1'b0;
      unique case (cmd[15:12])
         tsc_op_whi: wait_done = in_q[cmd[1:0]] ^ (ctrl[tsc_b_itm1] & ~in_q[cmd[1:0]]);
         tsc_op_wlo: wait_done = !in_q[cmd[1:0]] | (ctrl[tsc_b_itm0] & in_q[cmd[1:0]]);
         tsc_op_ctrl: wait_done = cmd[0] ? swt_pend : 1'b1;
         tsc_op_step: wait_done = step_delay_counter >= step_delay_limit;
         default: wait_done = 1'b1;
      endcase
   end
   // ----------------------------------------
   // command sequencer
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= tsc_idle;
      end else if (!active || !ctrl[tsc_b_run]) begin
         state <= tsc_idle;
      end else begin
         unique case (state)
            tsc_idle: if (cmd_pend && step_ok) state <= tsc_fetch;
            tsc_fetch: state <= tsc_wait;
            tsc_wait: if (wait_done) state <= (cmd[15:12] == tsc_op_trig) ? tsc_pulse : tsc_idle;
            tsc_pulse: state <= tsc_idle;
         endcase
      end
   end
   assign fire = state == tsc_pulse;
   // ----------------------------------------
   // counters and timers
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         step_delay_counter <= 16'h0000;
         loop_counter <= 16'h0000;
         sequence_timer <= 16'h0000;
      end else if (state == tsc_wait) begin
         step_delay_counter <= step_delay_counter + 16'h0001;
         sequence_timer <= (sequence_timer == timer_limit) ? 16'h0000 : sequence_timer + 16'h0001;
      end else begin
         step_delay_counter <= 16'h0000;
         if (fire) loop_counter <= (loop_counter == loop_counter_limit) ? 16'h0000 : loop_counter + 16'h0001;
      end
   end
   // ----------------------------------------
   // watchdog on waiting
   // ----------------------------------------
   logic [31:0] wd_cnt;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wd_cnt <= 32'h0000_0000;
      end else if (state == tsc_wait && !wait_done) begin
         wd_cnt <= wd_exp ? 32'h0000_0000 : wd_cnt + 32'h0000_0001;
      end else begin
         wd_cnt <= 32'h0000_0000;
      end
   end
   assign wd_exp = wd_cnt == 32'(wdt_cyc - 1);
   // sticky time-out flag, set wins over clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         watchdog_timeout_flag <= 1'b0;
      end else if (wd_exp) begin
         watchdog_timeout_flag <= 1'b1;
      end else if (wr && addr == tsc_addr_ctrl && !wdata[tsc_b_wdto]) begin
         watchdog_timeout_flag <= 1'b0;
      end
   end
   // ----------------------------------------
   // interrupt status and mask
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         stat <= '0;
      end else begin
         for (int i = 0; i < tsc_ev_w; i++) begin
            if ((i == 0 && wd_exp) || (i == 1 && fire)) begin
               stat[i] <= 1'b1;
            end else if (wr && addr == tsc_addr_stat && wdata[i]) begin
               stat[i] <= 1'b0;
            end
         end
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mask <= '0;
      end else if (wr && addr == tsc_addr_mask) begin
         mask <= wdata[tsc_ev_w-1:0];
      end
   end
   assign irq = |(stat & mask);
   // ----------------------------------------
   // trigger lines
   // ----------------------------------------
   for (genvar g = 0; g < n_lines; g++) begin : g_line
      tsc_trig_line #(.pw_w(8)) u_line (
         .mclk(mclk),
         .rst(rst),
         .fire(fire && cmd[3:0] == 4'(g)),
         .toggle(ctrl[tsc_b_togl]),
         .width(pulse_width_setting),
         .line(trigger_output_line[g])
      );
   end
   // ----------------------------------------
   // read path
   // ----------------------------------------
   always_comb begin
      ctrl_view = ctrl;
      ctrl_view[tsc_b_wdto] = watchdog_timeout_flag;
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata <= 16'h0000;
      end else if (rd) begin
         unique case (addr)
            tsc_addr_ctrl: rdata <= ctrl_view & tsc_ctrl_impl;
            tsc_addr_mask: rdata <= 16'(mask);
            tsc_addr_stat: rdata <= 16'(stat);
            tsc_addr_sdlim: rdata <= ctrl[tsc_b_ivis] ? step_delay_counter : step_delay_limit;
            tsc_addr_cnlim: rdata <= ctrl[tsc_b_ivis] ? loop_counter : loop_counter_limit;
            tsc_addr_tmlim: rdata <= ctrl[tsc_b_ivis] ? sequence_timer : timer_limit;
            tsc_addr_pwid: rdata <= {8'h00, pulse_width_setting};
            tsc_addr_cmd: rdata <= cmd;
            default: rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_disabled_idle;
      @(posedge mclk) disable iff (rst) !ctrl[tsc_b_enable] |=> state == tsc_idle;
   endproperty
   a_disabled_idle: assert property (p_disabled_idle) else $error("sequencer ran while disabled");
   property p_sidl;
      @(posedge mclk) disable iff (rst) (ctrl[tsc_b_sidl] && idle_q) |=> state == tsc_idle;
   endproperty
   a_sidl: assert property (p_sidl) else $error("sequencer ran in idle");
   property p_stop;
      @(posedge mclk) disable iff (rst) !ctrl[tsc_b_run] |=> !fire;
   endproperty
   a_stop: assert property (p_stop) else $error("trigger fired while stopped");
   property p_wdto;
      @(posedge mclk) disable iff (rst) wd_exp |=> watchdog_timeout_flag && stat[0];
   endproperty
   a_wdto: assert property (p_wdto) else $error("time-out not flagged");
   property p_sticky;
      @(posedge mclk) disable iff (rst) (watchdog_timeout_flag && !(wr && addr == tsc_addr_ctrl)) |=> watchdog_timeout_flag;
   endproperty
   a_sticky: assert property (p_sticky) else $error("time-out flag lost");
   property p_vis;
      @(posedge mclk) disable iff (rst) (rd && addr == tsc_addr_tmlim && !ctrl[tsc_b_ivis]) |=> rdata == $past(timer_limit);
   endproperty
   a_vis: assert property (p_vis) else $error("limit read wrong");
   property p_live;
      @(posedge mclk) disable iff (rst) (rd && addr == tsc_addr_sdlim && ctrl[tsc_b_ivis]) |=> rdata == $past(step_delay_counter);
   endproperty
   a_live: assert property (p_live) else $error("live read wrong");
   property p_unimpl;
      @(posedge mclk) disable iff (rst) ##1 (rdata & ~tsc_ctrl_impl) == 16'h0000 || $past(addr) != tsc_addr_ctrl;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bit read one");
   property p_swt_zero;
      @(posedge mclk) disable iff (rst) (!swt_pend && !(wr && addr == tsc_addr_ctrl && wdata[tsc_b_swt])) |=> !swt_pend;
   endproperty
   a_swt_zero: assert property (p_swt_zero) else $error("trigger without a one write");
   c_fire: cover property (@(posedge mclk) disable iff (rst) fire);
   c_wdto: cover property (@(posedge mclk) disable iff (rst) wd_exp);
   c_irq: cover property (@(posedge mclk) disable iff (rst) irq);
endmodule // tsc_core
`default_nettype wire

/* tsc_periph.sv */
// far-side peripherals: watch trigger outputs, drive trigger inputs
// assumes one clock mclk shared with the sequencer
`timescale 1ns/100ps
`default_nettype none
module tsc_periph (
   input wire logic mclk, // clock
   input wire logic rst, // async reset
   input wire logic [3:0] line, // trigger outputs seen
   input wire logic in_req, // input level asked by bench
   output logic [3:0] trig_in, // trigger inputs to sequencer
   output logic [7:0] n_rise, // pulses or rises seen
   output logic [7:0] last_w, // width of last pulse
   output logic [3:0] last_line // lines high at last rise
);
   logic any_q;
   logic [7:0] cnt;
   // ------------------------------
   // trigger input source
   // ------------------------------
   // unused inputs held low, as if pulled down
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) trig_in <= 4'h0;
      else trig_in <= {3'b000, in_req};
   end
   // ------------------------------
   // pulse monitor
   // ------------------------------
   // width counted in whole clock cycles
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         any_q <= 1'b0;
         cnt <= 8'h00;
         n_rise <= 8'h00;
         last_w <= 8'h00;
         last_line <= 4'h0;
      end else begin
         any_q <= |line;
         if (|line && !any_q) begin
            n_rise <= n_rise + 8'h01;
            last_line <= line;
            cnt <= 8'h01;
         end else if (|line) begin
            cnt <= cnt + 8'h01;
         end else if (any_q) begin
            last_w <= cnt;
         end
      end
   end
endmodule // tsc_periph
`default_nettype wire

/* trigger_sequencer_control_tb_top.sv */
// bench for trigger sequencer control: register tasks and scenarios
// assumes tsc_pkg, tsc_core and tsc_periph compiled before it
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin fails++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module trigger_sequencer_control_tb_top;
   import tsc_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic idle_req = 1'b0;
   logic in_req = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata;
   logic [3:0] trig_in;
   logic [3:0] lines;
   logic irq;
   logic [7:0] n_rise;
   logic [7:0] last_w;
   logic [3:0] last_line;
   logic [7:0] r0;
   logic [15:0] d;
   int fails = 0;
   int n_compared = 0;
   // ------------------------------
   // clock and instances
   // ------------------------------
   initial begin
      forever #2 mclk = ~mclk;
   end
   tsc_core #(.n_lines(4), .n_in(4), .wdt_cyc(8)) DUT (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .idle_req(idle_req), .trig_in(trig_in), .trigger_output_line(lines), .irq(irq));
   tsc_periph u_periph (.mclk(mclk), .rst(rst), .line(lines), .in_req(in_req), .trig_in(trig_in),
      .n_rise(n_rise), .last_w(last_w), .last_line(last_line));
   // ------------------------------
   // register port tasks
   // ------------------------------
   task automatic end_of_test();
      if (fails == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge mclk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic chk_reg(input string nm, input logic [3:0] a, input logic [15:0] m, input logic [15:0] ex);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      `CHK(nm, ex, rdata & m)
   endtask
   // one pulse expected on the line set in mask ln lasting w cycles
   task automatic catch_pulse(input logic [3:0] ln, input logic [7:0] w);
      int k;
      r0 = n_rise;
      for (k = 0; k < 40 && n_rise == r0; k++) @(posedge mclk);
      for (k = 0; k < 40 && lines !== 4'h0; k++) @(posedge mclk);
      if (k == 40) begin
         fails++;
         end_of_test();
      end
      repeat (2) @(posedge mclk);
      `CHK("pulse_count", r0 + 8'h01, n_rise)
      `CHK("pulse_width", w, last_w)
      `CHK("pulse_line", ln, last_line)
   endtask
   task automatic no_pulse(input string nm);
      r0 = n_rise;
      repeat (30) @(posedge mclk);
      `CHK(nm, r0, n_rise)
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      chk_reg("ctrl_rst", tsc_addr_ctrl, 16'hffff, 16'h0000);
      chk_reg("stat_rst", tsc_addr_stat, 16'hffff, 16'h0000);
      `CHK("irq_rst", 1'b0, irq)
      wr_reg(tsc_addr_ctrl, 16'h4c3c);
      chk_reg("ctrl_unimpl", tsc_addr_ctrl, 16'hffff, 16'h0000);
      wr_reg(tsc_addr_ctrl, 16'h3303);
      chk_reg("ctrl_rw", tsc_addr_ctrl, 16'hffff, 16'h3303);
      wr_reg(tsc_addr_ctrl, 16'h0000);
      for (int i = 3; i < 6; i++) begin
         wr_reg(4'(i), 16'h0a50 + 16'(i));
         chk_reg("limit_written", 4'(i), 16'hffff, 16'h0a50 + 16'(i));
      end
      chk_reg("unmapped", 4'hf, 16'hffff, 16'h0000);
      // single pulses, width zero counts as one
      wr_reg(tsc_addr_cmd, 16'h1002);
      wr_reg(tsc_addr_pwid, 16'h0000);
      wr_reg(tsc_addr_ctrl, 16'h8280);
      catch_pulse(4'h4, 8'h01);
      wr_reg(tsc_addr_pwid, 16'h0005);
      wr_reg(tsc_addr_cmd, 16'h1002);
      wr_reg(tsc_addr_ctrl, 16'h8280);
      catch_pulse(4'h4, 8'h05);
      chk_reg("stat_trig", tsc_addr_stat, 16'h0002, 16'h0002);
      wr_reg(tsc_addr_mask, 16'h0002);
      `CHK("irq_trig", 1'b1, irq)
      wr_reg(tsc_addr_stat, 16'h0002);
      `CHK("irq_clear", 1'b0, irq)
      // disabled, then halted in idle, then running in idle
      wr_reg(tsc_addr_cmd, 16'h1002);
      wr_reg(tsc_addr_ctrl, 16'h0280);
      no_pulse("disabled");
      wr_reg(tsc_addr_ctrl, 16'h0000);
      idle_req <= 1'b1;
      wr_reg(tsc_addr_ctrl, 16'ha280);
      no_pulse("idle_halt");
      wr_reg(tsc_addr_ctrl, 16'h0000);
      wr_reg(tsc_addr_ctrl, 16'h8280);
      catch_pulse(4'h4, 8'h05);
      idle_req <= 1'b0;
      // toggle mode keeps level between commands
      wr_reg(tsc_addr_ctrl, 16'h0000);
      wr_reg(tsc_addr_cmd, 16'h1001);
      wr_reg(tsc_addr_ctrl, 16'h9280);
      repeat (20) @(posedge mclk);
      `CHK("toggle_hi", 4'h2, lines)
      wr_reg(tsc_addr_cmd, 16'h1001);
      wr_reg(tsc_addr_ctrl, 16'h9280);
      repeat (20) @(posedge mclk);
      `CHK("toggle_lo", 4'h0, lines)
      // watchdog while waiting for input high
      wr_reg(tsc_addr_ctrl, 16'h0000);
      wr_reg(tsc_addr_cmd, 16'h2000);
      wr_reg(tsc_addr_mask, 16'h0001);
      wr_reg(tsc_addr_ctrl, 16'h8280);
      repeat (40) @(posedge mclk);
      chk_reg("wdto_set", tsc_addr_ctrl, 16'h0040, 16'h0040);
      `CHK("irq_wdto", 1'b1, irq)
      repeat (20) @(posedge mclk);
      chk_reg("wdto_sticky", tsc_addr_ctrl, 16'h0040, 16'h0040);
      wr_reg(tsc_addr_mask, 16'h0000);
      `CHK("irq_masked", 1'b0, irq)
      wr_reg(tsc_addr_ctrl, 16'h0000);
      wr_reg(tsc_addr_ctrl, 16'h0000);
      chk_reg("wdto_clr", tsc_addr_ctrl, 16'h0040, 16'h0000);
      wr_reg(tsc_addr_stat, 16'h0003);
      chk_reg("stat_clr", tsc_addr_stat, 16'h0003, 16'h0000);
      // input already high: wait ends, no time-out
      in_req <= 1'b1;
      repeat (6) @(posedge mclk);
      wr_reg(tsc_addr_cmd, 16'h2000);
      wr_reg(tsc_addr_ctrl, 16'h8280);
      repeat (40) @(posedge mclk);
      chk_reg("wdto_none", tsc_addr_ctrl, 16'h0040, 16'h0000);
      // wait low with input high times out
      wr_reg(tsc_addr_ctrl, 16'h0000);
      wr_reg(tsc_addr_cmd, 16'h3000);
      wr_reg(tsc_addr_ctrl, 16'h8280);
      repeat (40) @(posedge mclk);
      chk_reg("wdto_low", tsc_addr_ctrl, 16'h0040, 16'h0040);
      end_of_test();
   end
endmodule // trigger_sequencer_control_tb_top
`default_nettype wire
